// >>> logic/scfs_regs.sv
`timescale 1ns/100ps
// Contract
// - routing codes: none, modulator 0, modulator 1
// - step3 routing resets 00b/11b, upper nibble zero
// - repeat 00 never, 01-FE nth, FF once
// - count rounds or steps per step enable
// - residual calibration on nth when enabled
// - residual calibration only in first step
// - auto-zero on nth iteration when enabled
// - gain-control calibration needs round counting
// - recalibrate on gain change at step start
// - 16-bit measured period in 1.3888us ticks
// - reading period high byte clears hold
// - fast select 0 compares period bits 15:1
// - fast select 1 compares period bits 14:0
// - hold blocks period update until high read
// - trim modes: off, once, continuous, reserved
module scfs_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic syncPin,
  input wire logic holdPeriod,
  input wire logic [1:0] oscillator_trim_mode,
  input wire logic power_on_bit,
  input wire logic syncLost,
  input wire logic measActive,
  input wire logic stepCountEnable,
  input wire logic roundStart,
  input wire logic stepStart,
  input wire logic gainChanged,
  output logic [1:0] diode4Mod0,
  output logic [1:0] diode5Mod0,
  output logic calibResidual,
  output logic calibAutoZero,
  output logic calibGainCtl,
  output logic recalibGain,
  output logic trimRequest,
  output logic targetMatch,
  output logic holdActive
);
  logic [7:0] step3_upper_diode_routing;
  logic [7:0] calib_repeat_rate;
  logic [7:0] calib_type_enables;
  logic [15:0] syncPeriod;
  logic [14:0] syncTarget;
  logic fastTiming;
  logic holdFlag;
  logic [2:0] syncSync;
  logic syncLevel;
  logic syncEdge;
  logic tick;
  logic [15:0] tickCount;
  logic [7:0] iterCount;
  logic onceDone;
  logic iterEvent;
  logic nthHit;
  logic firstStep;
  logic gainPending;
  logic powerPrev;
  logic lostPrev;
  logic [14:0] periodView;
  logic [7:0] calib_repeat_count;

  assign calib_repeat_count = calib_repeat_rate;

  scfs_tick_div #(
    .CYCLES(scfs_pkg::TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .reset(reset),
    .tick(tick)
  );

  // host writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step3_upper_diode_routing <= scfs_pkg::RST_STEP3_ROUTING;
      calib_repeat_rate <= scfs_pkg::RST_CALIB_RATE;
      calib_type_enables <= scfs_pkg::RST_CALIB_ENABLES;
      syncTarget <= {scfs_pkg::RST_TARGET[6:0], scfs_pkg::RST_TARGET};
      fastTiming <= scfs_pkg::RST_TARGET[scfs_pkg::FAST_TIMING_BIT];
    end else if (regWrite) begin
      unique case (regAddr)
        scfs_pkg::ADDR_STEP3_ROUTING: step3_upper_diode_routing <= {4'h0, regWdata[3:0]};
        scfs_pkg::ADDR_CALIB_RATE: calib_repeat_rate <= regWdata;
        // reserved low nibble keeps its reset pattern
        scfs_pkg::ADDR_CALIB_ENABLES: calib_type_enables <= {regWdata[7:4], 4'h3};
        scfs_pkg::ADDR_TARGET_LOW: syncTarget[7:0] <= regWdata;
        scfs_pkg::ADDR_TARGET_HIGH: begin
          syncTarget[14:8] <= regWdata[6:0];
          fastTiming <= regWdata[scfs_pkg::FAST_TIMING_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux, registered data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        scfs_pkg::ADDR_STEP3_ROUTING: regRdata <= step3_upper_diode_routing;
        scfs_pkg::ADDR_CALIB_RATE: regRdata <= calib_repeat_rate;
        scfs_pkg::ADDR_CALIB_ENABLES: regRdata <= calib_type_enables;
        scfs_pkg::ADDR_PERIOD_LOW: regRdata <= syncPeriod[7:0];
        scfs_pkg::ADDR_PERIOD_HIGH: regRdata <= syncPeriod[15:8];
        scfs_pkg::ADDR_TARGET_LOW: regRdata <= syncTarget[7:0];
        scfs_pkg::ADDR_TARGET_HIGH: regRdata <= {fastTiming, syncTarget[14:8]};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  generate
    for (genvar d = 0; d < 2; d++) begin : g_route
      logic [1:0] code;
      logic [1:0] sel;
      assign code = step3_upper_diode_routing[2*d +: 2];
      always_comb begin
        unique case (code)
          scfs_pkg::ROUTE_MOD0: sel = 2'b01;
          scfs_pkg::ROUTE_MOD1: sel = 2'b10;
          default: sel = 2'b00;
        endcase
      end
      if (d == 0) begin : g_d4
        assign diode4Mod0 = sel;
      end else begin : g_d5
        assign diode5Mod0 = sel;
      end
    end
  endgenerate

  // pin sync: change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncSync <= 3'h0;
    end else begin
      syncSync <= {syncSync[1:0], syncPin};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncLevel <= 1'b0;
    end else if (syncSync[1] == syncSync[2]) begin
      syncLevel <= syncSync[2];
    end
  end

  assign syncEdge = (syncSync[1] == syncSync[2]) && syncSync[2] && !syncLevel;

  always_ff @(posedge ref_clk) begin
    if (reset || syncEdge) begin
      tickCount <= '0;
    end else if (tick && tickCount != 16'hFFFF) begin
      tickCount <= tickCount + 1'b1;
    end
  end

  // hold flag, read of high byte clears; a new set wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      holdFlag <= 1'b0;
    end else if (holdPeriod && syncEdge) begin
      holdFlag <= 1'b1;
    end else if (regRead && regAddr == scfs_pkg::ADDR_PERIOD_HIGH) begin
      holdFlag <= 1'b0;
    end
  end

  assign holdActive = holdFlag;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncPeriod <= {scfs_pkg::RST_PERIOD, scfs_pkg::RST_PERIOD};
    end else if (regWrite && regAddr == scfs_pkg::ADDR_PERIOD_LOW) begin
      syncPeriod[7:0] <= regWdata;
    end else if (regWrite && regAddr == scfs_pkg::ADDR_PERIOD_HIGH) begin
      syncPeriod[15:8] <= regWdata;
    end else if (syncEdge && !holdFlag) begin
      syncPeriod <= tickCount;
    end
  end

  assign periodView = fastTiming ? syncPeriod[14:0] : syncPeriod[15:1];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      targetMatch <= 1'b0;
    end else begin
      targetMatch <= (periodView == syncTarget);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      powerPrev <= 1'b0;
      lostPrev <= 1'b0;
    end else begin
      powerPrev <= power_on_bit;
      lostPrev <= syncLost;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trimRequest <= 1'b0;
    end else begin
      unique case (oscillator_trim_mode)
        scfs_pkg::TRIM_ONCE: begin
          if ((power_on_bit && !powerPrev) || (!syncLost && lostPrev)) begin
            trimRequest <= 1'b1;
          end else if (!measActive && trimRequest && syncEdge) begin
            trimRequest <= 1'b0;
          end
        end
        scfs_pkg::TRIM_ALWAYS: trimRequest <= !measActive && !syncLost;
        default: trimRequest <= 1'b0;
      endcase
    end
  end

  assign iterEvent = stepCountEnable ? stepStart : roundStart;
  assign firstStep = roundStart;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      iterCount <= 8'h00;
      onceDone <= 1'b0;
    end else if (regWrite && regAddr == scfs_pkg::ADDR_CALIB_RATE) begin
      iterCount <= 8'h00;
      onceDone <= 1'b0;
    end else if (iterEvent) begin
      onceDone <= 1'b1;
      if (iterCount >= calib_repeat_count - 8'h01) begin
        iterCount <= 8'h00;
      end else begin
        iterCount <= iterCount + 8'h01;
      end
    end
  end

  always_comb begin
    if (calib_repeat_count == scfs_pkg::REPEAT_NEVER) begin
      nthHit = 1'b0;
    end else if (calib_repeat_count == scfs_pkg::REPEAT_ONCE) begin
      nthHit = iterEvent && !onceDone;
    end else begin
      nthHit = iterEvent && (iterCount >= calib_repeat_count - 8'h01);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      calibResidual <= 1'b0;
      calibAutoZero <= 1'b0;
      calibGainCtl <= 1'b0;
    end else begin
      calibResidual <= nthHit && firstStep && calib_type_enables[scfs_pkg::EN_RESIDUAL_BIT];
      calibAutoZero <= nthHit && calib_type_enables[scfs_pkg::EN_AUTOZERO_BIT];
      // gain control; step counting would misplace it, so rounds only
      calibGainCtl <= nthHit && !stepCountEnable
                      && calib_type_enables[scfs_pkg::EN_GAINCTL_BIT];
    end
  end

  // gain change latched until next step start
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gainPending <= 1'b0;
      recalibGain <= 1'b0;
    end else begin
      recalibGain <= stepStart && (gainPending || gainChanged)
                     && calib_type_enables[scfs_pkg::EN_REGAIN_BIT];
      if (gainChanged) begin
        gainPending <= 1'b1;
      end else if (stepStart) begin
        gainPending <= 1'b0;
      end
    end
  end
endmodule : scfs_regs

// >>> logic/scfs_pkg.sv
package scfs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_STEP3_ROUTING = 8'hE3;
  localparam logic [7:0] ADDR_CALIB_RATE = 8'hE4;
  localparam logic [7:0] ADDR_CALIB_ENABLES = 8'hE6;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'hF2;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'hF3;
  localparam logic [7:0] ADDR_TARGET_LOW = 8'hF4;
  localparam logic [7:0] ADDR_TARGET_HIGH = 8'hF5;
  // reset values
  localparam logic [7:0] RST_STEP3_ROUTING = 8'h03;
  localparam logic [7:0] RST_CALIB_RATE = 8'hFF;
  localparam logic [7:0] RST_CALIB_ENABLES = 8'hD3;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_TARGET = 8'h00;
  // field positions
  localparam int DIODE4_LSB = 0;
  localparam int DIODE5_LSB = 2;
  localparam int EN_RESIDUAL_BIT = 7;
  localparam int EN_AUTOZERO_BIT = 6;
  localparam int EN_GAINCTL_BIT = 5;
  localparam int EN_REGAIN_BIT = 4;
  localparam int FAST_TIMING_BIT = 7;
  // repetition codes
  localparam logic [7:0] REPEAT_NEVER = 8'h00;
  localparam logic [7:0] REPEAT_ONCE = 8'hFF;
  // routing codes
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_MOD0 = 2'h1;
  localparam logic [1:0] ROUTE_MOD1 = 2'h2;
  // oscillator trim modes
  localparam logic [1:0] TRIM_OFF = 2'h0;
  localparam logic [1:0] TRIM_ONCE = 2'h1;
  localparam logic [1:0] TRIM_ALWAYS = 2'h2;
  // period tick: 1.3888 us at 200 MHz
  localparam int TICK_PS = 1388800;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_CYCLES = TICK_PS / CLK_PERIOD_PS;
endpackage : scfs_pkg

// >>> logic/scfs_tick_div.sv
`timescale 1ns/100ps
module scfs_tick_div #(
  parameter int CYCLES = 277
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  logic [CW-1:0] count;

  // a one-cycle divider would never drop its enable
  if (CYCLES < 2) begin : g_bad_cycles
    $error("divider needs at least two cycles");
  end

  always_ff @(posedge ref_clk) begin
    if (reset || count == CW'(CYCLES - 1)) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= (count == CW'(CYCLES - 1));
    end
  end
endmodule : scfs_tick_div

// >>> testbench/scfs_regs_asserts.sv
`timescale 1ns/100ps
module scfs_regs_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic holdPeriod,
  input wire logic [1:0] oscillator_trim_mode,
  input wire logic roundStart,
  input wire logic stepStart,
  input wire logic [1:0] diode4Mod0,
  input wire logic [1:0] diode5Mod0,
  input wire logic calibResidual,
  input wire logic calibAutoZero,
  input wire logic calibGainCtl,
  input wire logic stepCountEnable,
  input wire logic recalibGain,
  input wire logic trimRequest,
  input wire logic holdActive
);
  logic [7:0] rate;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // the repeat rate is shadowed here so that the never code can be seen at the ports
  always_ff @(posedge ref_clk) begin
    if (reset) rate <= 8'hFF;
    else if (regWrite && regAddr == 8'hE4) rate <= regWdata;
  end
  sequence highRead;
    regRead && regAddr == 8'hF3 && !holdPeriod;
  endsequence
  sequence trimOff;
    (oscillator_trim_mode == 2'h0) [*2];
  endsequence
  AST_HOLD_CLEAR: assert property (highRead |=> !holdActive) else $error("hold kept");
  AST_STEP3_RSVD: assert property (regRead && regAddr == 8'hE3 |=> regRdata[7:4] == 4'h0)
    else $error("routing upper nibble set");
  AST_ROUTE: assert property (diode4Mod0 != 2'h3 && diode5Mod0 != 2'h3)
    else $error("diode on both modulators");
  AST_RES_PULSE: assert property (calibResidual |=> !calibResidual) else $error("res long");
  AST_RES_ROUND: assert property (calibResidual |-> $past(roundStart)) else $error("res");
  AST_AZ_PULSE: assert property (calibAutoZero |=> !calibAutoZero) else $error("az long");
  AST_NEVER: assert property (rate == 8'h00 && $past(rate) == 8'h00 |-> !calibAutoZero)
    else $error("calibration with never code");
  AST_REGAIN: assert property (recalibGain |-> $past(stepStart)) else $error("regain");
  AST_GC_ROUNDS: assert property (calibGainCtl |-> !$past(stepCountEnable))
    else $error("gain-control calibration with step counting");
  AST_TRIM_OFF: assert property (trimOff |-> !trimRequest) else $error("trim while off");
  AST_RST: assert property ($fell(reset) |-> regRdata == 8'h00 && !holdActive)
    else $error("outputs not clear after reset");
endmodule : scfs_regs_asserts
bind scfs_regs scfs_regs_asserts chk (.*);

// >>> testbench/scfs_sync_src.sv
`timescale 1ns/100ps
module scfs_sync_src (
  input wire logic ref_clk,
  input wire logic run,
  input wire integer gapTicks,
  output logic syncPin = 1'b0
);
  int cnt = 0;
  // short pulse every gapTicks ticks; the pin stays low while stopped
  always @(posedge ref_clk) begin
    cnt <= (!run || cnt >= gapTicks * scfs_pkg::TICK_CYCLES - 1) ? 0 : cnt + 1;
    syncPin <= run && cnt < 4;
  end
endmodule : scfs_sync_src

// >>> testbench/sequencer_calib_and_frame_sync_regs_test.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module sequencer_calib_and_frame_sync_regs_test;
  logic ref_clk = 0, reset = 1, regWrite = 0, regRead = 0, syncRun = 0, holdPeriod = 0;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, rdVal;
  logic power_on_bit = 0, syncLost = 0, measActive = 0, syncPin, holdActive;
  logic stepCountEnable = 0, roundStart = 0, stepStart = 0, gainChanged = 0;
  logic [1:0] oscillator_trim_mode = 0, diode4Mod0, diode5Mod0;
  logic calibResidual, calibAutoZero, calibGainCtl, recalibGain, trimRequest, targetMatch;
  logic [15:0] per;
  int mismatches = 0, compares = 0, cyc = 0, gap = 6, cnt, n, pend;
  logic [7:0] mdl [logic [7:0]];
  logic [7:0] addrs [8] = '{8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hF2, 8'hF3, 8'hF4, 8'hF5};
  scfs_regs dut (.*);
  scfs_sync_src src (.ref_clk(ref_clk), .run(syncRun), .gapTicks(gap), .syncPin(syncPin));
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic rst();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    mdl = '{8'hE3: 8'h03, 8'hE4: 8'hFF, 8'hE6: 8'hD3, 8'hF2: 0, 8'hF3: 0, 8'hF4: 0, 8'hF5: 0};
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    if (mdl.exists(a)) mdl[a] = a == 8'hE3 ? d & 8'h0F : a == 8'hE6 ? {d[7:4], 4'h3} : d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    // data stands until the next read, so take it one edge later
    @(posedge ref_clk);
    rdVal = regRdata;
  endtask : rd
  task automatic checkRegs();
    foreach (addrs[i]) begin
      rd(addrs[i]);
      `CHK("reg", mdl.exists(addrs[i]) ? mdl[addrs[i]] : 8'h00, rdVal)
    end
  endtask : checkRegs
  task automatic waitSync(input int k);
    repeat (k) @(posedge syncPin);
    repeat (8) @(posedge ref_clk);
  endtask : waitSync
  task automatic perChk(input int g);
    rd(8'hF2);
    per[7:0] = rdVal;
    rd(8'hF3);
    per[15:8] = rdVal;
    `CHK("period", 1'b1, per >= g - 1 && per <= g)
  endtask : perChk
  task automatic ev(input logic r, input logic g);
    logic hit;
    logic [7:0] e;
    e = mdl[8'hE6];
    if (g) begin
      @(posedge ref_clk);
      gainChanged <= 1'b1;
      pend = 1;
    end
    @(posedge ref_clk);
    gainChanged <= 1'b0;
    roundStart <= r;
    stepStart <= 1'b1;
    @(posedge ref_clk);
    roundStart <= 1'b0;
    stepStart <= 1'b0;
    @(posedge ref_clk);
    // rounds or single steps advance the count
    if (r || stepCountEnable) cnt++;
    hit = (r || stepCountEnable) && (n == 255 ? cnt == 1 : n != 0 && cnt % n == 0);
    `CHK("az", hit && e[6], calibAutoZero)
    `CHK("res", hit && e[7] && r, calibResidual)
    `CHK("gc", hit && e[5], calibGainCtl)
    `CHK("regain", pend != 0 && e[4], recalibGain)
    pend = 0;
  endtask : ev
  initial begin
    logic [15:0] tgt;
    logic [15:0] pt [4] = '{16'h2EE0, 16'hAEE0, 16'hAEE0, 16'h5DC0};
    int rates [5] = '{3, 2, 255, 0, 1};
    void'($urandom(32'hC2A9C738));
    rst();
    checkRegs();
    `CHK("d4", 2'h0, diode4Mod0)
    repeat (12) wr(addrs[$urandom_range(7, 0)], 8'($urandom));
    checkRegs();
    for (int c = 0; c < 16; c++) begin
      wr(8'hE3, {4'hF, c[3:0]});
      // decode follows the register, which lands at the write edge
      @(posedge ref_clk);
      `CHK("d4", c[1:0] == 2'h3 ? 2'h0 : c[1:0], diode4Mod0)
      `CHK("d5", c[3:2] == 2'h3 ? 2'h0 : c[3:2], diode5Mod0)
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      tgt = i[0] ? 720000 / 60 : 720000 / 60 / 2;
      wr(8'hF2, pt[i][7:0]);
      wr(8'hF3, pt[i][15:8]);
      wr(8'hF4, tgt[7:0]);
      wr(8'hF5, {i[0], tgt[14:8]});
      repeat (3) @(posedge ref_clk);
      `CHK("match", i[0] ? pt[i][14:0] == tgt[14:0] : pt[i][15:1] == tgt[14:0], targetMatch)
    end
    $display("test target done");
    syncRun <= 1'b1;
    waitSync(3);
    perChk(6);
    holdPeriod <= 1'b1;
    waitSync(1);
    holdPeriod <= 1'b0;
    `CHK("hold", 1'b1, holdActive)
    gap = 4;
    waitSync(2);
    perChk(6);
    `CHK("hold", 1'b0, holdActive)
    waitSync(2);
    perChk(4);
    oscillator_trim_mode <= 2'h2;
    repeat (20) @(posedge ref_clk);
    `CHK("trim", 1'b1, trimRequest)
    oscillator_trim_mode <= 2'h1;
    waitSync(1);
    `CHK("trim", 1'b0, trimRequest)
    power_on_bit <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK("trim", 1'b1, trimRequest)
    measActive <= 1'b1;
    waitSync(1);
    `CHK("trim", 1'b1, trimRequest)
    syncLost <= 1'b1;
    oscillator_trim_mode <= 2'h2;
    repeat (3) @(posedge ref_clk);
    `CHK("trim", 1'b0, trimRequest)
    syncLost <= 1'b0;
    measActive <= 1'b0;
    oscillator_trim_mode <= 2'h0;
    syncRun <= 1'b0;
    $display("test sync done");
    foreach (rates[i]) begin
      rst();
      n = i == 4 ? $urandom_range(4, 1) : rates[i];
      stepCountEnable <= i == 1;
      wr(8'hE4, n[7:0]);
      tgt[7:0] = 8'($urandom);
      if (i == 1) tgt[5] = 1'b0;
      wr(8'hE6, tgt[7:0]);
      cnt = 0;
      pend = 0;
      repeat (8) ev(1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)));
    end
    $display("test schedule done");
    summarize();
  end
endmodule : sequencer_calib_and_frame_sync_regs_test
